// ### core/vectored_priority_interrupt_unit.sv
// Purpose: vectored priority interrupt unit with standby wake logic
// Assumes: pins come from outside ref_clk and are synchronised here;
//          peripheral requests are single-cycle or level, same clock
// Notes:   one interrupt is presented at a time; the core acks to take it
`timescale 1ns/1ps
`default_nettype none
module vectored_priority_interrupt_unit
  import vpiu_pkg::*;
(
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  // external pins (asynchronous)
  input  wire logic                          ext_irq_pin_a,
  input  wire logic                          ext_irq_pin_b,
  input  wire logic                          ext_irq_pin_c,
  input  wire logic                          ext_irq_pin_d,
  input  wire logic                          reset_pin,
  input  wire logic [2:0]                    wake_level_abc,
  // peripheral requests (same clock, pulse)
  input  wire logic                          timer_zero_low_irq,
  input  wire logic                          timer_zero_high_irq,
  input  wire logic                          timer_four_irq,
  input  wire logic                          timer_five_irq,
  input  wire logic                          sync_serial_irq,
  input  wire logic                          async_serial_irq,
  input  wire logic                          adc_irq,
  input  wire logic                          remote_irq,
  input  wire logic                          base_timer_irq,
  input  wire logic                          port0_irq,
  // control from the core
  input  wire logic [vpiu_pkg::NUM_VECTORS-1:0] level_select,
  input  wire logic [vpiu_pkg::NUM_VECTORS-1:0] vector_enable,
  input  wire logic                          irq_ack,
  input  wire logic                          irq_return,
  input  wire logic                          enter_halt,
  input  wire logic                          enter_full_hold,
  input  wire logic                          enter_xtal_hold,
  // to the core
  output logic                               irq_req,
  output logic [vpiu_pkg::ADDR_W-1:0]        irq_vector_addr,
  output logic [1:0]                         irq_level,
  output logic [1:0]                         active_level,
  output logic                               core_run,
  output logic                               base_timer_run,
  output logic [vpiu_pkg::NUM_VECTORS-1:0]   pending
);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  logic [4:0] pin_prev;
  logic [4:0] next_pin_meta;
  logic [4:0] next_pin_sync;
  logic [4:0] next_pin_prev;

  // first stage feeds only the second stage
  always_comb
  begin
    next_pin_meta = {reset_pin, ext_irq_pin_d, ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a};
    next_pin_sync = pin_meta;
    next_pin_prev = pin_sync;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pin_meta <= 5'h1f;
      pin_sync <= 5'h1f;
      pin_prev <= 5'h1f;
    end
    else
    begin
      pin_meta <= next_pin_meta;
      pin_sync <= next_pin_sync;
      pin_prev <= next_pin_prev;
    end
  end

  // ---------------------------------------------------------------
  // source to vector mapping
  // ---------------------------------------------------------------
  logic [NUM_SOURCES-1:0] src;
  logic [NUM_VECTORS-1:0] vec_hit;
  logic [2:0]             pin_fall;
  // external pins request on a falling edge; the word is packed highest source position first
  assign pin_fall = pin_prev[2:0] & ~pin_sync[2:0];
  assign src      = {timer_five_irq, timer_four_irq, port0_irq, adc_irq, async_serial_irq, sync_serial_irq,
                     timer_zero_high_irq, base_timer_irq, pin_prev[3] & ~pin_sync[3], remote_irq,
                     timer_zero_low_irq, pin_fall};

  // shared vectors or their sources together; vector 5 has no source
  assign vec_hit[0] = src[SRC_PIN_A];
  assign vec_hit[1] = src[SRC_PIN_B];
  assign vec_hit[2] = src[SRC_PIN_C] | src[SRC_T0L] | src[SRC_REMOTE];
  assign vec_hit[3] = src[SRC_PIN_D] | src[SRC_BASE_TMR];
  assign vec_hit[4] = src[SRC_T0H];
  assign vec_hit[5] = 1'b0;
  assign vec_hit[6] = src[SRC_SYNC_SER];
  assign vec_hit[7] = src[SRC_ASYN_SER];
  assign vec_hit[8] = src[SRC_ADC];
  assign vec_hit[9] = src[SRC_PORT0] | src[SRC_T4] | src[SRC_T5];

  // ---------------------------------------------------------------
  // per-vector level and pending flags
  // ---------------------------------------------------------------
  logic [1:0] vec_level [NUM_VECTORS];
  logic [NUM_VECTORS-1:0] next_pending;
  logic [NUM_VECTORS-1:0] take_clear;
  genvar gv;
  generate
    for (gv = 0; gv < NUM_VECTORS; gv++)
    begin : g_vec
      // select bit picks the upper level of the pair
      if (gv < NUM_X_VECTORS)
      begin : g_x
        assign vec_level[gv] = level_select[gv] ? LVL_HIGHEST : LVL_LOW;
      end
      else
      begin : g_h
        assign vec_level[gv] = level_select[gv] ? LVL_HIGH : LVL_LOW;
      end
      // a new event wins over the clear of the same cycle
      assign next_pending[gv] = vec_hit[gv] | (pending[gv] & ~take_clear[gv]);
    end
  endgenerate

  // ---------------------------------------------------------------
  // arbitration
  // ---------------------------------------------------------------
  logic [1:0]             best_level;
  logic [3:0]             best_idx;
  logic                   best_valid;

  // ascending scan with strict compare keeps the lowest address on ties
  always_comb
  begin
    best_level = LVL_NONE;
    best_idx   = 4'h0;
    best_valid = 1'b0;
    for (int i = 0; i < NUM_VECTORS; i++)
    begin
      if (pending[i] && vector_enable[i] && vec_level[i] > best_level)
      begin
        best_level = vec_level[i];
        best_idx   = 4'(i);
        best_valid = 1'b1;
      end
    end
    best_valid = best_valid && (best_level > active_level);
  end

  // ---------------------------------------------------------------
  // service nesting stack and request output
  // ---------------------------------------------------------------
  logic [2:0]  level_stack;          // one flag per level being serviced
  logic [2:0]  next_level_stack;
  logic [1:0]  next_active_level;
  logic        next_irq_req;
  logic [19:0] next_irq_vector_addr;
  logic [1:0]  next_irq_level;
  logic        accept;
  logic [3:0]  req_idx;              // index of the vector now presented

  assign accept  = irq_req && irq_ack;
  assign req_idx = 4'((irq_vector_addr - VEC_BASE) / VEC_STEP);  // shown vector, not a newer winner

  always_comb
  begin
    take_clear       = '0;
    next_level_stack = level_stack;
    if (accept)
      take_clear[req_idx] = 1'b1;
    // a return closes the innermost level first
    if (irq_return)
    begin
      if (level_stack[2])
        next_level_stack[2] = 1'b0;
      else if (level_stack[1])
        next_level_stack[1] = 1'b0;
      else
        next_level_stack[0] = 1'b0;
    end
    if (accept)
      next_level_stack[irq_level - 2'h1] = 1'b1;
    next_active_level = next_level_stack[2] ? LVL_HIGHEST :
                        next_level_stack[1] ? LVL_HIGH :
                        next_level_stack[0] ? LVL_LOW : LVL_NONE;
    // request is a registered copy of the winner, dropped on accept
    next_irq_req         = best_valid && !accept;
    next_irq_vector_addr = VEC_BASE + VEC_STEP * 20'(best_idx);
    next_irq_level       = best_level;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pending         <= '0;
      level_stack     <= 3'h0;
      active_level    <= LVL_NONE;
      irq_req         <= 1'b0;
      irq_vector_addr <= VEC_BASE;
      irq_level       <= LVL_NONE;
    end
    else
    begin
      pending         <= next_pending;
      level_stack     <= next_level_stack;
      active_level    <= next_active_level;
      irq_req         <= next_irq_req;
      irq_vector_addr <= next_irq_vector_addr;
      irq_level       <= next_irq_level;
    end
  end

  // ---------------------------------------------------------------
  // standby control
  // ---------------------------------------------------------------
  standby_type mode;
  standby_type next_mode;
  logic        hold_wake;
  logic        next_core_run;
  logic        next_base_timer_run;

  // levels are compared after sync; a wake pulse inside hold is not lost
  assign hold_wake = !pin_sync[4] || (|(~(pin_sync[2:0] ^ wake_level_abc))) || port0_irq;

  always_comb
  begin
    next_mode = mode;
    case (mode)
      RUNNING:
      begin
        if (enter_halt)
          next_mode = HALT;
        else if (enter_full_hold)
          next_mode = FULL_HOLD;
        else if (enter_xtal_hold)
          next_mode = XTAL_HOLD;
      end
      HALT:
      begin
        if (best_valid)
          next_mode = RUNNING;
      end
      FULL_HOLD:
      begin
        if (hold_wake)
          next_mode = RUNNING;
      end
      XTAL_HOLD:
      begin
        if (hold_wake || base_timer_irq || remote_irq)
          next_mode = RUNNING;
      end
      default:
        next_mode = RUNNING;
    endcase
    next_core_run       = (next_mode == RUNNING);
    next_base_timer_run = (next_mode != FULL_HOLD);
  end

  // system reset returns to running, ending halt as well
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      mode           <= RUNNING;
      core_run       <= 1'b1;
      base_timer_run <= 1'b1;
    end
    else
    begin
      mode           <= next_mode;
      core_run       <= next_core_run;
      base_timer_run <= next_base_timer_run;
    end
  end

endmodule
`default_nettype wire

// ### core/vpiu_pkg.sv
// Purpose: constants and types for the vectored priority interrupt unit
// Assumes: 100 MHz ref_clk, 14 sources gathered onto 10 vectors
// Notes:   vector addresses start at 0x0003 and step by eight
package vpiu_pkg;
  localparam int          NUM_VECTORS   = 10;
  localparam int          NUM_SOURCES   = 14;
  localparam int          ADDR_W        = 20;
  localparam logic [19:0] VEC_BASE      = 20'h00003;
  localparam logic [19:0] VEC_STEP      = 20'h00008;
  localparam int          NUM_X_VECTORS = 2;  // first two vectors may pick highest
  // source bit positions in the request word
  localparam int SRC_PIN_A    = 0;
  localparam int SRC_PIN_B    = 1;
  localparam int SRC_PIN_C    = 2;
  localparam int SRC_T0L      = 3;
  localparam int SRC_REMOTE   = 4;
  localparam int SRC_PIN_D    = 5;
  localparam int SRC_BASE_TMR = 6;
  localparam int SRC_T0H      = 7;
  localparam int SRC_SYNC_SER = 8;
  localparam int SRC_ASYN_SER = 9;
  localparam int SRC_ADC      = 10;
  localparam int SRC_PORT0    = 11;
  localparam int SRC_T4       = 12;
  localparam int SRC_T5       = 13;
  // priority levels, encoded so that a larger code is a higher level
  localparam logic [1:0] LVL_NONE    = 2'h0;
  localparam logic [1:0] LVL_LOW     = 2'h1;
  localparam logic [1:0] LVL_HIGH    = 2'h2;
  localparam logic [1:0] LVL_HIGHEST = 2'h3;
  typedef enum logic [1:0] {RUNNING, HALT, FULL_HOLD, XTAL_HOLD} standby_type;
endpackage

// ### tb/vpiu_asserts.sv
// Purpose: port checks for the interrupt unit
// Assumes: bound onto the top module, one clock domain
// Notes:   level codes compare directly, larger is higher
`timescale 1ns/1ps
`default_nettype none
module vpiu_asserts
  import vpiu_pkg::*;
(
  // clock and reset
  input wire logic                             ref_clk,
  input wire logic                             rst_n,
  // sources and core handshake
  input wire logic                             adc_irq,
  input wire logic                             timer_four_irq,
  input wire logic                             port0_irq,
  input wire logic                             irq_ack,
  // outputs watched
  input wire logic                             irq_req,
  input wire logic [vpiu_pkg::ADDR_W-1:0]      irq_vector_addr,
  input wire logic [1:0]                       irq_level,
  input wire logic [1:0]                       active_level,
  input wire logic                             core_run,
  input wire logic                             base_timer_run,
  input wire logic [vpiu_pkg::NUM_VECTORS-1:0] pending
);
  // ----
  // checks
  // ----
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // the core takes the presented vector at this edge
  sequence s_take;
    irq_req && irq_ack;
  endsequence
  a_req_above: assert property (irq_req |-> irq_level > active_level)
    else $error("request not above service level");
  a_level_legal: assert property (irq_req |-> irq_level != LVL_NONE)
    else $error("request without a level");
  a_vec_align: assert property (irq_req |-> irq_vector_addr[2:0] == 3'h3 && irq_vector_addr <= 20'h0004b)
    else $error("vector address off the table");
  a_req_stands: assert property (irq_req && !irq_ack |=> irq_req)
    else $error("request withdrawn before ack");
  a_ack_drop: assert property (s_take |=> !irq_req)
    else $error("request still up after ack");
  a_ack_nest: assert property (s_take |=> active_level == $past(irq_level))
    else $error("service level not taken from ack");
  a_src_pend: assert property ((adc_irq || timer_four_irq) |=> pending[8] || pending[9])
    else $error("source pulse not latched");
  a_hold_wake: assert property (!base_timer_run && port0_irq |-> ##[1:4] core_run)
    else $error("full hold not left on port event");
  a_timer_stop: assert property (!base_timer_run |-> !core_run)
    else $error("timer stopped while core runs");
endmodule
`default_nettype wire

// ### tb/core_model.sv
// Purpose: processor core taking vectored requests
// Assumes: requests stand until the ack edge
// Notes:   dly sets how slowly the core answers
`timescale 1ns/1ps
`default_nettype none
module core_model
(
  // clock
  input wire logic       ref_clk,
  // from bench and unit
  input wire logic       ack_en,
  input wire logic [3:0] dly,
  input wire logic       irq_req,
  // to unit and bench
  output var logic       irq_ack,
  output var logic       took
);
  logic [3:0] cnt;
  initial
  begin
    irq_ack = 1'b0;
    took = 1'b0;
    cnt = 4'h0;
  end
  // ack held one edge only; took stays until the bench withdraws ack_en
  always @(posedge ref_clk)
  begin
    if (irq_ack)
    begin
      irq_ack <= 1'b0;
      took <= 1'b1;
    end
    else if (!ack_en)
    begin
      took <= 1'b0;
      cnt <= 4'h0;
    end
    else if (irq_req && !took)
    begin
      if (cnt >= dly)
        irq_ack <= 1'b1;
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### tb/vectored_priority_interrupt_unit_tb.sv
// Purpose: self-checking bench for the interrupt unit
// Assumes: inputs change at the falling edge
// Notes:   model keeps pending flags and a stack of levels
`timescale 1ns/1ps
`default_nettype none
module vectored_priority_interrupt_unit_tb;
  import vpiu_pkg::*;
  logic ref_clk, rst_n, reset_pin, irq_ack, irq_return, ack_en, took, irq_req, core_run, base_timer_run;
  logic [13:0] src;
  logic [9:0]  level_select, mp, pending;
  logic [2:0]  ent, wl;
  logic [3:0]  dly;
  logic [19:0] irq_vector_addr;
  logic [1:0]  irq_level, active_level;
  int          seed = 85, miscompares = 0, checked = 0, stk[$];
  int          vec_of[14] = '{0, 1, 2, 3, 2, 2, 3, 4, 6, 7, 8, 9, 9, 9};
  int          sm[6] = '{1, 1, 1, 2, 2, 0};
  int          ss[6] = '{11, -1, 0, 5, 6, 10};
  // ----
  // unit and core
  // ----
  vectored_priority_interrupt_unit dut_u (.ref_clk, .rst_n, .ext_irq_pin_a(~src[0]), .ext_irq_pin_b(~src[1]),
    .ext_irq_pin_c(~src[2]), .ext_irq_pin_d(~src[3]), .reset_pin, .wake_level_abc(wl),
    .timer_zero_low_irq(src[4]), .remote_irq(src[5]), .base_timer_irq(src[6]), .timer_zero_high_irq(src[7]),
    .sync_serial_irq(src[8]), .async_serial_irq(src[9]), .adc_irq(src[10]), .port0_irq(src[11]),
    .timer_four_irq(src[12]), .timer_five_irq(src[13]), .level_select, .vector_enable(10'h3ff), .irq_ack,
    .irq_return, .enter_halt(ent[2]), .enter_full_hold(ent[1]), .enter_xtal_hold(ent[0]), .irq_req,
    .irq_vector_addr, .irq_level, .active_level, .core_run, .base_timer_run, .pending);
  core_model core_u (.ref_clk, .ack_en, .dly, .irq_req, .irq_ack, .took);
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task chk(input logic [19:0] got, input logic [19:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // upper level is highest only on the first two vectors
  function automatic int lv(int v);
    return level_select[v] ? (v < 2 ? 3 : 2) : 1;
  endfunction
  function automatic int top();
    return stk.size() ? stk[$] : 0;
  endfunction
  // strict compare keeps the lowest vector on a tie
  function automatic int best();
    int b = -1;
    for (int v = 0; v < 10; v++)
      if (mp[v] && lv(v) > top() && (b < 0 || lv(v) > lv(b))) b = v;
    return b;
  endfunction
  // pins stay low a while so the synchroniser sees the edge
  task fire(input logic [13:0] m);
    @(negedge ref_clk) src = m;
    for (int i = 0; i < 14; i++) if (m[i]) mp[vec_of[i]] = 1'b1;
    @(negedge ref_clk) src = m & 14'hf;
    repeat (3) @(negedge ref_clk);
    src = 14'h0;
    repeat (3) @(negedge ref_clk);
    chk(20'(pending), 20'(mp));
  endtask
  task step;
    int e, n;
    @(negedge ref_clk);
    e = best();
    n = 0;
    while (irq_req !== 1'b1 && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 40) miscompares++;
    chk(irq_vector_addr, 20'h3 + 20'(8 * e));
    chk(20'(irq_level), 20'(lv(e)));
    ack_en = 1'b1;
    n = 0;
    while (took !== 1'b1 && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 40) miscompares++;
    ack_en = 1'b0;
    mp[e] = 1'b0;
    stk.push_back(lv(e));
    chk(20'(active_level), 20'(lv(e)));
    chk(20'(pending), 20'(mp));
  endtask
  task quiet;
    repeat (2) @(negedge ref_clk);
    chk(20'(irq_req), 20'h0);
  endtask
  task drain;
    while (best() >= 0) step();
    while (stk.size() > 0)
    begin
      quiet();
      @(negedge ref_clk) irq_return = 1'b1;
      @(negedge ref_clk) irq_return = 1'b0;
      void'(stk.pop_back());
      chk(20'(active_level), 20'(top()));
      while (best() >= 0) step();
    end
    quiet();
  endtask
  task stby(input int m, input int s);
    @(negedge ref_clk) ent = 3'b100 >> m;
    @(negedge ref_clk) ent = 3'h0;
    repeat (2) @(negedge ref_clk);
    chk(20'({core_run, base_timer_run}), 20'(m != 1));
    if (s < 0)
    begin
      reset_pin = 1'b0;
      repeat (6) @(negedge ref_clk);
      reset_pin = 1'b1;
    end
    else
      fire(14'h1 << s);
    chk(20'(core_run), 20'h1);
    drain();
  endtask
  task test_done;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, far beyond the expected run
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    test_done();
  end
  // random mixes with random levels, then at least one wake path of each standby mode
  initial
  begin
    rst_n = 1'b0;
    src = 14'h0;
    reset_pin = 1'b1;
    irq_return = 1'b0;
    ack_en = 1'b0;
    ent = 3'h0;
    wl = 3'h0;
    dly = 4'h0;
    level_select = 10'h0;
    mp = 10'h0;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk({7'h0, irq_req, core_run, base_timer_run, pending}, 20'h00c00);
    for (int k = 0; k < 20; k++)
    begin
      level_select = 10'($random(seed));
      dly = 4'($random(seed));
      fire(14'($random(seed)));
      if (best() >= 0) step();
      fire(14'($random(seed)));
      drain();
    end
    for (int k = 0; k < 6; k++) stby(sm[k], ss[k]);
    // a high wake level on pin b matches the idle pin, so full hold ends at once
    wl = 3'h2;
    @(negedge ref_clk) ent = 3'h2;
    @(negedge ref_clk) ent = 3'h0;
    chk(20'({core_run, base_timer_run}), 20'h0);
    repeat (2) @(negedge ref_clk);
    chk(20'({core_run, base_timer_run}), 20'h3);
    test_done();
  end
endmodule
bind vectored_priority_interrupt_unit vpiu_asserts chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .adc_irq(adc_irq),
  .timer_four_irq(timer_four_irq), .port0_irq(port0_irq), .irq_ack(irq_ack), .irq_req(irq_req),
  .irq_vector_addr(irq_vector_addr), .irq_level(irq_level), .active_level(active_level),
  .core_run(core_run), .base_timer_run(base_timer_run), .pending(pending));
`default_nettype wire
